// [dv/adc_fmt_top_assertions.sv]
/* Port checker for adc_fmt_top, bound below.
   Assumes one clock domain, clk_sys_i. */
`timescale 1ns/1ps
module adc_fmt_top_assertions
    import adc_fmt_pkg::*;
#(parameter int CONV_DIV = 10) (
    input wire logic        clk_sys_i, rst_i, shift_load_n_i, serial_clk_i, serial_bit_out_o,
    input wire logic        below_range_flag_o, above_range_flag_o, sample_window_o, conv_clk_o,
    input wire logic [11:0] conversion_word_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    property p_below;
        below_range_flag_o |-> !above_range_flag_o && conversion_word_o[10:0] inside {11'h000, 11'h7FF};
    endproperty
    a_below: assert property (p_below) else $error("word not full scale when below");
    property p_above; above_range_flag_o |-> !below_range_flag_o; endproperty
    a_above: assert property (p_above) else $error("both range flags high");
    property p_period; $rose(conv_clk_o) |-> ##CONV_DIV $rose(conv_clk_o); endproperty
    a_period: assert property (p_period) else $error("conversion period wrong");
    property p_win_lo; $fell(conv_clk_o) |-> ##[0:1] !sample_window_o; endproperty
    a_win_lo: assert property (p_win_lo) else $error("window not low in hold");
    property p_win_hi; $rose(conv_clk_o) |-> ##[0:1] sample_window_o; endproperty
    a_win_hi: assert property (p_win_hi) else $error("window not high in track");
    property p_word; $changed(conversion_word_o) |-> ##[0:1] conv_clk_o; endproperty
    a_word: assert property (p_word) else $error("word changed off latch");
    property p_flag; $changed({below_range_flag_o, above_range_flag_o}) |-> ##[0:1] conv_clk_o; endproperty
    a_flag: assert property (p_flag) else $error("flag changed off latch");
    property p_load;
        (!shift_load_n_i && $stable(conversion_word_o))[*5] |-> serial_bit_out_o == conversion_word_o[11];
    endproperty
    a_load: assert property (p_load) else $error("load does not show top bit");
    property p_hold;
        (shift_load_n_i && $stable(serial_clk_i))[*6] |-> $stable(serial_bit_out_o);
    endproperty
    a_hold: assert property (p_hold) else $error("serial out moved without clock");
    c_below: cover property (below_range_flag_o);
    c_load: cover property (!shift_load_n_i ##1 shift_load_n_i);
    c_shift: cover property (shift_load_n_i && $rose(serial_clk_i));
endmodule // adc_fmt_top_assertions
bind adc_fmt_top adc_fmt_top_assertions #(.CONV_DIV(CONV_DIV)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .shift_load_n_i(shift_load_n_i), .serial_clk_i(serial_clk_i),
    .serial_bit_out_o(serial_bit_out_o), .below_range_flag_o(below_range_flag_o),
    .above_range_flag_o(above_range_flag_o), .sample_window_o(sample_window_o), .conv_clk_o(conv_clk_o),
    .conversion_word_o(conversion_word_o));

// [dv/adc_fmt_top_tb.sv]
/* Testbench for adc_fmt_top: formats, flags, latency, serial port, APB.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module adc_fmt_top_tb
    import adc_fmt_pkg::*;
;
    localparam int DIV = 10;
    logic        clk_sys_i = 1'b0, rst_i = 1'b1, top_i = 1'b0, low_i = 1'b0;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] raw = 12'h000, paddr = 12'h000, word;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    range_t      rng = range_ok;
    logic        ld_n, sclk, serial_bit_out, below, above, win, cclk, pready, pslverr;
    logic [12:0] bits;
    int          n_errors = 0, checked = 0, cyc = 0;
    always #5 clk_sys_i = ~clk_sys_i;
    adc_fmt_top #(.CONV_DIV(DIV)) uut (
        .clk_sys_i(clk_sys_i), .rst_i(rst_i), .raw_code_i(raw), .range_i(rng), .top_bit_invert_i(top_i),
        .lower_bits_invert_i(low_i), .shift_load_n_i(ld_n), .serial_clk_i(sclk), .serial_bit_out_o(serial_bit_out),
        .below_range_flag_o(below), .above_range_flag_o(above), .sample_window_o(win), .conv_clk_o(cclk),
        .conversion_word_o(word), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    adc_serial_host host (.shift_load_n_o(ld_n), .serial_clk_o(sclk), .serial_bit_i(serial_bit_out));
    task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
        checked++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys_i);
        penable <= 1'b1;
        do @(posedge clk_sys_i); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic drive(logic [1:0] f, logic [11:0] c, range_t r);
        while (cclk !== 1'b0) @(posedge clk_sys_i);
        top_i <= f[1];
        low_i <= f[0];
        raw <= c;
        rng <= r;
        repeat (5 * DIV) @(posedge clk_sys_i);
    endtask
    task automatic wfall();
        do @(negedge clk_sys_i); while (win !== 1'b1);
        do @(negedge clk_sys_i); while (win !== 1'b0);
        @(posedge clk_sys_i);
    endtask
    task automatic results();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc++;
        if (cyc > 5000) begin
            n_errors++;
            results();
        end
    end
    initial begin
        repeat (8) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        @(posedge clk_sys_i);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl reset", 32'h0, rd);
        apb(1'b1, 12'h000, 32'h1);
        apb(1'b0, 12'h000, 32'h0);
        chk("ctrl", 32'h1, rd);
        drive(2'b00, 12'h5A3, range_ok);
        chk("word ctrl", 32'hDA3, word);
        apb(1'b1, 12'h000, 32'h0);
        apb(1'b0, 12'h010, 32'h0);
        chk("unmapped", 32'h0, rd);
        chk("pslverr", 32'h0, {31'h0, pslverr});
        chk("pready", 32'h1, {31'h0, pready});
        $display("test registers done");
        for (int f = 0; f < 4; f++) begin
            drive(f[1:0], 12'h5A3, range_ok);
            chk("word", 12'h5A3 ^ {f[1], {11{f[0]}}}, word);
            chk("flags", 32'h0, {below, above});
        end
        drive(2'b11, 12'h5A3, range_below);
        chk("below word", 32'hFFF, word);
        chk("below flags", 32'h2, {below, above});
        apb(1'b0, 12'h004, 32'h0);
        chk("status", 32'h1, rd[1:0]);
        drive(2'b10, 12'h5A3, range_above);
        chk("above flags", 32'h1, {below, above});
        host.read_bits(bits);
        chk("serial above", {12'h7FF, 1'b0}, bits);
        drive(2'b10, 12'h9C3, range_ok);
        host.read_bits(bits);
        chk("serial", {12'h1C3, 1'b0}, bits);
        $display("test formats and serial done");
        drive(2'b00, 12'h123, range_ok);
        wfall();
        raw <= 12'h456;
        wfall();
        raw <= 12'h789;
        repeat (20) @(posedge clk_sys_i);
        chk("latency old", 32'h123, word);
        repeat (10) @(posedge clk_sys_i);
        chk("latency", 32'h456, word);
        repeat (10) @(posedge clk_sys_i);
        chk("latency next", 32'h789, word);
        $display("test latency done");
        results();
    end
endmodule // adc_fmt_top_tb

// [dv/adc_serial_host.sv]
/* Host side of the serial readout port.
   Assumes its serial clock is unrelated to the system clock. */
`timescale 1ns/1ps
module adc_serial_host (
    // serial port
    output logic      shift_load_n_o,
    output logic      serial_clk_o,
    input  wire logic serial_bit_i
);
    initial begin
        shift_load_n_o = 1'b1;
        serial_clk_o = 1'b0;
    end
    // load, clocking meanwhile, then take thirteen bits
    task automatic read_bits(output logic [12:0] w);
        #3;
        shift_load_n_o = 1'b0;
        repeat (2) begin
            #62.5 serial_clk_o = 1'b1;
            #62.5 serial_clk_o = 1'b0;
        end
        #100 shift_load_n_o = 1'b1;
        #100;
        for (int i = 12; i >= 0; i--) begin
            w[i] = serial_bit_i;
            #62.5 serial_clk_o = 1'b1;
            #62.5 serial_clk_o = 1'b0;
        end
    endtask
endmodule // adc_serial_host

// [verilog/adc_fmt_pkg.sv]
/*
 * Types shared by the converter output formatter files.
 * Assumes adc_fmt_regs.svh is on the include path.
 */
`include "adc_fmt_regs.svh"
package adc_fmt_pkg;
    typedef enum logic [1:0] {
        range_ok    = 2'b00,
        range_below = 2'b01,
        range_above = 2'b10
    } range_t;

    typedef struct packed {
        logic [`WORD_W-1:0] code;
        logic               below_range_flag;
        logic               above_range_flag;
    } conv_t;

    typedef struct packed {
        logic top_bit_invert;
        logic lower_bits_invert;
    } fmt_sel_t;
endpackage

// [verilog/adc_fmt_regs.svh]
/*
 * Constants for the converter output formatter and serial readout port:
 * word width, pipeline depth, register offsets and reset values.
 * Assumes inclusion by bare name from the package and the design modules.
 */
`ifndef ADC_FMT_REGS_SVH
`define ADC_FMT_REGS_SVH

`define WORD_W            12
`define TOP_BIT           11
`define PIPE_STAGES       2
`define CONV_DIV_DEFAULT  100
`define REG_CTRL          12'h000
`define REG_STATUS        12'h004
`define REG_SAMPLE        12'h008
`define REG_RESULT        12'h00C
`define CTRL_TOP_INV_BIT  0
`define CTRL_LOW_INV_BIT  1
`define CTRL_RESET        32'h0000_0000

`endif

// [verilog/adc_fmt_top.sv]
/*
 * Digital output side of a twelve bit converter: range flags, output
 * format selection, conversion pipeline, sample window and serial port.
 * Assumes the analog front end delivers a raw code and a range verdict
 * each conversion; pins come from outside the clock domain.
 */
// The address map and the APB slave port are this design's own decisions.
// Operation
// - below-range flag low normally, high while input under bottom reference.
// - below range forces data to bottom full-scale code.
// - above-range flag low normally, high while input over top reference.
// - after load, serial output shows most significant bit first.
// - each serial clock rise advances serial output one bit.
// - load low copies the current word continuously, over serial clock.
// - shifting only happens while load is high.
// - sample window high while tracking, low while holding.
// - value at sample window fall is the one digitized.
// - analog input sampled on falling edge of conversion clock.
// - twelve data bits formatted by the two format selects.
// - both selects low gives straight binary.
// - top-bit invert select inverts bit 11.
// - lower-bits invert select inverts bits 0 to 10.
// - range flags unaffected by format selects.
// - new format takes effect at the next output register update.
// - format selects default low when undriven; here the pins have no pull-down, so an undriven pin is unknown.
// - new word each conversion, two and a half cycle latency.
`timescale 1ns/1ps
module adc_fmt_top
    import adc_fmt_pkg::*;
#(
    parameter int CONV_DIV = `CONV_DIV_DEFAULT
) (
    // clock and reset
    input  wire logic               clk_sys_i,
    input  wire logic               rst_i,
    // front end
    input  wire logic [`WORD_W-1:0] raw_code_i,
    input  wire range_t             range_i,
    // format pins
    input  wire logic               top_bit_invert_i,
    input  wire logic               lower_bits_invert_i,
    // serial port pins
    input  wire logic               shift_load_n_i,
    input  wire logic               serial_clk_i,
    output      logic               serial_bit_out_o,
    // status pins
    output      logic               below_range_flag_o,
    output      logic               above_range_flag_o,
    output      logic               sample_window_o,
    output      logic               conv_clk_o,
    output      logic [`WORD_W-1:0] conversion_word_o,
    // apb
    input  wire logic               psel,
    input  wire logic               penable,
    input  wire logic               pwrite,
    input  wire logic [11:0]        paddr,
    input  wire logic [31:0]        pwdata,
    output      logic [31:0]        prdata,
    output      logic               pready,
    output      logic               pslverr
);
    localparam int HALF = CONV_DIV / 2;

    function automatic logic [`WORD_W-1:0] fmt_code(input logic [`WORD_W-1:0] c,
                                                     input fmt_sel_t s);
        fmt_code = {c[`TOP_BIT] ^ s.top_bit_invert,
                    c[`TOP_BIT-1:0] ^ {`TOP_BIT{s.lower_bits_invert}}};
    endfunction

    // pin synchronisation
    logic [3:0] pins_s;
    adc_sync2 #(.W(4)) u_sync (
        .clk_sys_i (clk_sys_i),
        .async_i   ({top_bit_invert_i, lower_bits_invert_i, shift_load_n_i, serial_clk_i}),
        .sync_o    (pins_s)
    );

    logic [31:0] ctrl;
    fmt_sel_t    sel;
    // an undriven pin is not pulled low; each select ORs the synchronised pin with its ctrl bit
    assign sel.top_bit_invert    = pins_s[3] | ctrl[`CTRL_TOP_INV_BIT];
    assign sel.lower_bits_invert = pins_s[2] | ctrl[`CTRL_LOW_INV_BIT];

    // conversion clock: enable pulses at rise and fall
    logic [15:0] div_cnt;
    logic        rise_en;
    logic        fall_en;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i || div_cnt == 16'(CONV_DIV - 1)) div_cnt <= 16'h0000;
        else div_cnt <= div_cnt + 16'h0001;
    end
    assign rise_en = (div_cnt == 16'h0000);
    assign fall_en = (div_cnt == 16'(HALF));

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) conv_clk_o <= 1'b0;
        else if (rise_en) conv_clk_o <= 1'b1;
        else if (fall_en) conv_clk_o <= 1'b0;
    end

    // track while clock high, hold from the falling edge
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) sample_window_o <= 1'b0;
        else if (rise_en) sample_window_o <= 1'b1;
        else if (fall_en) sample_window_o <= 1'b0;
    end

    // pipeline: capture at fall, two stages at falls, output latch at rise
    conv_t smp;
    conv_t pipe [`PIPE_STAGES];
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            smp <= '0;
            for (int i = 0; i < `PIPE_STAGES; i++) pipe[i] <= '0;
        end else if (fall_en) begin
            smp.code             <= (range_i == range_below) ? '0 :
                                    (range_i == range_above) ? '1 : raw_code_i;
            smp.below_range_flag <= (range_i == range_below);
            smp.above_range_flag <= (range_i == range_above);
            pipe[0]              <= smp;
            pipe[1]              <= pipe[0];
        end
    end

    // output latch, format applied when it is enabled
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            conversion_word_o  <= '0;
            below_range_flag_o <= 1'b0;
            above_range_flag_o <= 1'b0;
        end else if (rise_en) begin
            conversion_word_o  <= fmt_code(pipe[1].code, sel);
            below_range_flag_o <= pipe[1].below_range_flag;
            above_range_flag_o <= pipe[1].above_range_flag;
        end
    end

    // serial clock edge detect on synchronised level
    logic sclk_d;
    always_ff @(posedge clk_sys_i) begin
        if (rst_i) sclk_d <= 1'b0;
        else sclk_d <= pins_s[0];
    end

    adc_shift_port #(.W(`WORD_W)) u_shift (
        .clk_sys_i        (clk_sys_i),
        .rst_i            (rst_i),
        .load_n_i         (pins_s[1]),
        .sclk_rise_i      (pins_s[0] & ~sclk_d),
        .word_i           (conversion_word_o),
        .serial_bit_out_o (serial_bit_out_o)
    );

    // apb slave, zero wait states
    logic wr_hit;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;
    assign wr_hit  = psel && penable && pwrite && paddr == `REG_CTRL;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) ctrl <= `CTRL_RESET;
        else if (wr_hit) ctrl <= {30'h0000_0000, pwdata[1:0]};
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            case (paddr)
                `REG_CTRL:   prdata <= ctrl;
                `REG_STATUS: prdata <= {26'h000_0000, sel.lower_bits_invert, sel.top_bit_invert,
                                        sample_window_o, conv_clk_o,
                                        above_range_flag_o, below_range_flag_o};
                `REG_SAMPLE: prdata <= {20'h0_0000, pipe[1].code};
                `REG_RESULT: prdata <= {20'h0_0000, conversion_word_o};
                default:     prdata <= 32'h0000_0000;
            endcase
        end
    end
endmodule // adc_fmt_top

// [verilog/adc_shift_port.sv]
/*
 * Serial readout shift register: level load, shift on serial clock rise.
 * Assumes shift_load_n and serial clock are already synchronised.
 */
`timescale 1ns/1ps
module adc_shift_port
    import adc_fmt_pkg::*;
#(
    parameter int W = `WORD_W
) (
    // clock and reset
    input  wire logic         clk_sys_i,
    input  wire logic         rst_i,
    // control
    input  wire logic         load_n_i,
    input  wire logic         sclk_rise_i,
    input  wire logic [W-1:0] word_i,
    // serial out
    output      logic         serial_bit_out_o
);
    logic [W-1:0] shreg;

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            shreg <= '0;
        end else if (!load_n_i) begin
            shreg <= word_i;
        end else if (sclk_rise_i) begin
            shreg <= {shreg[W-2:0], 1'b0};
        end
    end

    assign serial_bit_out_o = shreg[W-1];
endmodule // adc_shift_port

// [verilog/adc_sync2.sv]
/*
 * Two flip-flop synchroniser for pin-level inputs.
 * Assumes the input is asynchronous to clk_sys_i.
 */
`timescale 1ns/1ps
module adc_sync2 #(
    parameter int W = 1
) (
    // clock
    input  wire logic         clk_sys_i,
    // data
    input  wire logic [W-1:0] async_i,
    output      logic [W-1:0] sync_o
);
    logic [W-1:0] meta;

    always_ff @(posedge clk_sys_i) begin
        meta   <= async_i;
        sync_o <= meta;
    end
endmodule // adc_sync2
